/* logic/debug_strobe_port.sv */
// Protocol debug strobe port: two selectable debug output pins
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
module debug_strobe_port #(
	parameter int unsigned STATE_W = 5  // Protocol state code width
) (
	input  wire logic               sys_clk,
	input  wire logic               reset,
	// Avalon-MM slave
	input  wire logic [3:0]         address,
	input  wire logic               read,
	input  wire logic               write,
	input  wire logic [31:0]        writedata,
	input  wire logic [3:0]         byteenable,
	output logic      [31:0]        readdata,
	output logic                    waitrequest,
	// Protocol engine events
	input  wire logic [STATE_W-1:0] protocol_state,
	input  wire logic               static_slot_start,
	input  wire logic               minislot_start,
	input  wire logic               dyn_slot_start_chan_a,
	input  wire logic               dyn_slot_start_chan_b,
	input  wire logic               frame_start_chan_a,
	input  wire logic               frame_start_chan_b,
	input  wire logic               frame_end_chan_a,
	input  wire logic               frame_end_chan_b,
	input  wire logic               frame_ok_chan_a,
	input  wire logic               frame_ok_chan_b,
	input  wire logic               bit_tick_chan_a,
	input  wire logic               bit_tick_chan_b,
	input  wire logic               cycle_start,
	input  wire logic               network_idle_start,
	input  wire logic               macrotick_tick,
	input  wire logic               offset_corr_tick,
	input  wire logic               filtered_rx_chan_a,
	input  wire logic               filtered_rx_chan_b,
	input  wire logic               bus_guardian_attached,
	// Debug pins
	output logic                    debug_output_one,
	output logic                    debug_output_two
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	dbg_port_pkg::bus_state_t bus_state;       // Slave state

	logic [3:0]               sel_pin1;        // Pin one function
	logic [3:0]               sel_pin2;        // Pin two function
	logic [STATE_W-1:0]       state_prev;      // Last protocol state
	logic                     state_primed;    // Prev state is valid
	logic                     state_change;    // Change event pulse
	logic                     static_pulse;    // One-clock slot strobe
	logic                     cycle_level;     // Cycle in progress
	logic                     rx_a;            // Registered RxD A
	logic                     rx_b;            // Registered RxD B
	logic [1:0]               valid_fire;      // Delayed valid pulses
	logic [dbg_port_pkg::NUM_STR-1:0] str_evt; // Raw events
	logic [dbg_port_pkg::NUM_STR-1:0] str_out; // Stretched strobes
	logic [1:0]               pin_q;           // Pin flops
	logic [3:0]               pin_sel [2];     // Select per pin
	logic [1:0]               fend;            // Frame end per channel
	logic [1:0]               fok;             // Frame valid per channel
	logic [1:0]               btick;           // Bit tick per channel
	logic [31:0]              next_readdata;   // Read mux result
	logic                     write_go;        // Write accepted

	// ----------------------------------------
	// Protocol state change detect
	// ----------------------------------------
	// First cycle after reset only primes the history
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			state_prev   <= '0;
			state_primed <= 1'b0;
			state_change <= 1'b0;
		end
		else
		begin
			state_prev   <= protocol_state;
			state_primed <= 1'b1;
			// Any new code counts as a change
			state_change <= state_primed &&
				(protocol_state != state_prev);
		end
	end

	// ----------------------------------------
	// Static slot start: one clock only
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			static_pulse <= 1'b0;
		end
		else
		begin
			static_pulse <= static_slot_start;
		end
	end

	// ----------------------------------------
	// Communication cycle level
	// ----------------------------------------
	// A cycle start in the idle start cycle wins
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			cycle_level <= 1'b0;
		end
		else if (cycle_start)
		begin
			cycle_level <= 1'b1;
		end
		else if (network_idle_start)
		begin
			cycle_level <= 1'b0;
		end
	end

	// ----------------------------------------
	// Filtered receive data, unshaped
	// ----------------------------------------
	// One stage keeps latency equal to the strobes
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			rx_a <= 1'b0;
			rx_b <= 1'b0;
		end
		else
		begin
			rx_a <= filtered_rx_chan_a;
			rx_b <= filtered_rx_chan_b;
		end
	end

	// ----------------------------------------
	// Valid frame indication delay per channel
	// ----------------------------------------
	assign fend  = {frame_end_chan_b, frame_end_chan_a};
	assign fok   = {frame_ok_chan_b, frame_ok_chan_a};
	assign btick = {bit_tick_chan_b, bit_tick_chan_a};

	generate
		for (genvar ch = 0; ch < 2; ch++)
		begin : g_valid
			logic [3:0] bits_seen;  // Bit ticks since frame end
			logic       armed;      // Valid frame awaiting indication

			// Counts bus bits after a valid frame end
			always_ff @(posedge sys_clk or posedge reset)
			begin
				if (reset)
				begin
					bits_seen      <= '0;
					armed          <= 1'b0;
					valid_fire[ch] <= 1'b0;
				end
				else if (fend[ch] && fok[ch])
				begin
					// New valid frame restarts the count
					bits_seen      <= '0;
					armed          <= 1'b1;
					valid_fire[ch] <= 1'b0;
				end
				else if (armed && btick[ch])
				begin
					if (bits_seen ==
						4'(dbg_port_pkg::VALID_BITS - 1))
					begin
						// Eleventh bit after end sequence
						armed          <= 1'b0;
						valid_fire[ch] <= 1'b1;
					end
					else
					begin
						bits_seen      <= bits_seen + 4'h1;
						valid_fire[ch] <= 1'b0;
					end
				end
				else
				begin
					valid_fire[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Raw events feeding the stretchers
	// ----------------------------------------
	always_comb
	begin
		str_evt = '0;
		str_evt[dbg_port_pkg::IX_STATE]   = state_change;
		str_evt[dbg_port_pkg::IX_MINI]    = minislot_start;
		str_evt[dbg_port_pkg::IX_DYN_A]   = dyn_slot_start_chan_a;
		str_evt[dbg_port_pkg::IX_DYN_B]   = dyn_slot_start_chan_b;
		str_evt[dbg_port_pkg::IX_FRAME_A] = frame_start_chan_a;
		str_evt[dbg_port_pkg::IX_FRAME_B] = frame_start_chan_b;
		str_evt[dbg_port_pkg::IX_VALID_A] = valid_fire[0];
		str_evt[dbg_port_pkg::IX_VALID_B] = valid_fire[1];
		str_evt[dbg_port_pkg::IX_MTICK]   = macrotick_tick;
		str_evt[dbg_port_pkg::IX_OFFSET]  = offset_corr_tick;
	end

	// ----------------------------------------
	// Three-clock stretchers, one per function except static slot, RxD and cycle
	// ----------------------------------------
	generate
		for (genvar i = 0; i < dbg_port_pkg::NUM_STR; i++)
		begin : g_str
			strobe_stretch #(
				.HOLD  (dbg_port_pkg::HOLD_CYCLES),
				.CNT_W (2)
			) u_str (
				.sys_clk     (sys_clk),
				.reset       (reset),
				.event_pulse (str_evt[i]),
				.stretched   (str_out[i])
			);
		end
	endgenerate

	// ----------------------------------------
	// Function select mux
	// ----------------------------------------
	function automatic logic pick(input logic [3:0] code);
		logic v;
		v = 1'b0;
		case (code)
			dbg_port_pkg::FN_STATE_CHANGE: v = str_out[dbg_port_pkg::IX_STATE];
			dbg_port_pkg::FN_STATIC_SLOT:  v = static_pulse;
			dbg_port_pkg::FN_MINISLOT:     v = str_out[dbg_port_pkg::IX_MINI];
			dbg_port_pkg::FN_RX_A:         v = rx_a;
			dbg_port_pkg::FN_DYN_SLOT_A:   v = str_out[dbg_port_pkg::IX_DYN_A];
			dbg_port_pkg::FN_FRAME_A:      v = str_out[dbg_port_pkg::IX_FRAME_A];
			dbg_port_pkg::FN_VALID_A:      v = str_out[dbg_port_pkg::IX_VALID_A];
			dbg_port_pkg::FN_CYCLE:        v = cycle_level;
			dbg_port_pkg::FN_MACROTICK:    v = str_out[dbg_port_pkg::IX_MTICK];
			dbg_port_pkg::FN_OFFSET_CORR:  v = str_out[dbg_port_pkg::IX_OFFSET];
			dbg_port_pkg::FN_RX_B:         v = rx_b;
			dbg_port_pkg::FN_DYN_SLOT_B:   v = str_out[dbg_port_pkg::IX_DYN_B];
			dbg_port_pkg::FN_FRAME_B:      v = str_out[dbg_port_pkg::IX_FRAME_B];
			dbg_port_pkg::FN_VALID_B:      v = str_out[dbg_port_pkg::IX_VALID_B];
			// Unused codes keep the pin low
			default:                       v = 1'b0;
		endcase
		return v;
	endfunction : pick

	assign pin_sel[0] = sel_pin1;
	assign pin_sel[1] = sel_pin2;

	// ----------------------------------------
	// Pin output flops
	// ----------------------------------------
	generate
		for (genvar p = 0; p < 2; p++)
		begin : g_pin
			// Each pin picks its own function
			always_ff @(posedge sys_clk or posedge reset)
			begin
				if (reset)
				begin
					pin_q[p] <= 1'b0;
				end
				else if (bus_guardian_attached)
				begin
					// Pins belong to the guardian
					pin_q[p] <= 1'b0;
				end
				else
				begin
					pin_q[p] <= pick(pin_sel[p]);
				end
			end
		end
	endgenerate

	assign debug_output_one = pin_q[0];
	assign debug_output_two = pin_q[1];

	// ----------------------------------------
	// Register read mux
	// ----------------------------------------
	always_comb
	begin
		next_readdata = '0;
		case (address)
			dbg_port_pkg::OFS_PIN_SELECT:
			begin
				next_readdata[dbg_port_pkg::SEL1_LSB +: 4] = sel_pin1;
				next_readdata[dbg_port_pkg::SEL2_LSB +: 4] = sel_pin2;
			end
			dbg_port_pkg::OFS_STATUS:
			begin
				next_readdata[dbg_port_pkg::ST_PIN1]  = pin_q[0];
				next_readdata[dbg_port_pkg::ST_PIN2]  = pin_q[1];
				next_readdata[dbg_port_pkg::ST_CYCLE] = cycle_level;
				next_readdata[dbg_port_pkg::ST_GUARD] = bus_guardian_attached;
				next_readdata[dbg_port_pkg::ST_STR_LSB +:
					dbg_port_pkg::NUM_STR] = str_out;
			end
			// Unmapped offsets read zero
			default: next_readdata = '0;
		endcase
	end

	// ----------------------------------------
	// Avalon slave handshake
	// ----------------------------------------
	// One wait cycle, then one cycle with waitrequest low
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			bus_state   <= dbg_port_pkg::BUS_IDLE;
			waitrequest <= 1'b1;
			readdata    <= '0;
		end
		else
		begin
			unique case (bus_state)
				dbg_port_pkg::BUS_IDLE:
				begin
					if (read || write)
					begin
						bus_state   <= dbg_port_pkg::BUS_ANSWER;
						waitrequest <= 1'b0;
						readdata    <= read ? next_readdata : '0;
					end
				end
				dbg_port_pkg::BUS_ANSWER:
				begin
					// Master releases at this edge
					bus_state   <= dbg_port_pkg::BUS_IDLE;
					waitrequest <= 1'b1;
				end
			endcase
		end
	end

	assign write_go = write && !waitrequest;

	// ----------------------------------------
	// Select register write
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			sel_pin1 <= dbg_port_pkg::SEL_RESET;
			sel_pin2 <= dbg_port_pkg::SEL_RESET;
		end
		else if (write_go && (address == dbg_port_pkg::OFS_PIN_SELECT))
		begin
			if (byteenable[0])
			begin
				sel_pin1 <= writedata[dbg_port_pkg::SEL1_LSB +: 4];
			end
			if (byteenable[1])
			begin
				sel_pin2 <= writedata[dbg_port_pkg::SEL2_LSB +: 4];
			end
		end
	end

endmodule : debug_strobe_port

/* logic/dbg_port_pkg.sv */
// Constants shared by the debug strobe port and its helpers
package dbg_port_pkg;

	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BE_W   = 4;

	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [3:0] OFS_PIN_SELECT = 4'h0;
	localparam logic [3:0] OFS_STATUS     = 4'h4;

	// ----------------------------------------
	// Select register fields
	// ----------------------------------------
	localparam int unsigned SEL_W      = 4;
	localparam int unsigned SEL1_LSB   = 0;
	localparam int unsigned SEL2_LSB   = 8;
	localparam logic [3:0]  SEL_RESET  = 4'hF;

	// ----------------------------------------
	// Status register fields
	// ----------------------------------------
	localparam int unsigned ST_PIN1    = 0;
	localparam int unsigned ST_PIN2    = 1;
	localparam int unsigned ST_CYCLE   = 2;
	localparam int unsigned ST_GUARD   = 3;
	localparam int unsigned ST_STR_LSB = 4;

	// ----------------------------------------
	// Function codes; 4'hE and 4'hF drive low
	// ----------------------------------------
	localparam logic [3:0] FN_STATE_CHANGE = 4'h0;
	localparam logic [3:0] FN_STATIC_SLOT  = 4'h1;
	localparam logic [3:0] FN_MINISLOT     = 4'h2;
	localparam logic [3:0] FN_RX_A         = 4'h3;
	localparam logic [3:0] FN_DYN_SLOT_A   = 4'h4;
	localparam logic [3:0] FN_FRAME_A      = 4'h5;
	localparam logic [3:0] FN_VALID_A      = 4'h6;
	localparam logic [3:0] FN_CYCLE        = 4'h7;
	localparam logic [3:0] FN_MACROTICK    = 4'h8;
	localparam logic [3:0] FN_OFFSET_CORR  = 4'h9;
	localparam logic [3:0] FN_RX_B         = 4'hA;
	localparam logic [3:0] FN_DYN_SLOT_B   = 4'hB;
	localparam logic [3:0] FN_FRAME_B      = 4'hC;
	localparam logic [3:0] FN_VALID_B      = 4'hD;

	// ----------------------------------------
	// Stretched strobe vector indices
	// ----------------------------------------
	localparam int unsigned NUM_STR    = 10;
	localparam int unsigned IX_STATE   = 0;
	localparam int unsigned IX_MINI    = 1;
	localparam int unsigned IX_DYN_A   = 2;
	localparam int unsigned IX_FRAME_A = 3;
	localparam int unsigned IX_VALID_A = 4;
	localparam int unsigned IX_MTICK   = 5;
	localparam int unsigned IX_OFFSET  = 6;
	localparam int unsigned IX_DYN_B   = 7;
	localparam int unsigned IX_FRAME_B = 8;
	localparam int unsigned IX_VALID_B = 9;

	// ----------------------------------------
	// Timing counts in controller clocks / bits
	// ----------------------------------------
	localparam int unsigned HOLD_CYCLES = 3;
	localparam int unsigned VALID_BITS  = 11;

	// Bus slave states
	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_t;

endpackage : dbg_port_pkg

/* logic/strobe_stretch.sv */
// Stretches a one-cycle event into a fixed-length high pulse
`timescale 1ns/10ps
module strobe_stretch #(
	parameter int unsigned HOLD  = dbg_port_pkg::HOLD_CYCLES,
	parameter int unsigned CNT_W = 2
) (
	input  wire logic sys_clk,      // Controller clock
	input  wire logic reset,        // Async reset, active high
	input  wire logic event_pulse,  // One-cycle event
	output logic      stretched     // High for HOLD cycles
);

	localparam logic [CNT_W-1:0] RELOAD = CNT_W'(HOLD - 1);

	logic [CNT_W-1:0] remain;  // Cycles still to hold after this

	// ----------------------------------------
	// Hold counter; a new event restarts it
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			remain    <= '0;
			stretched <= 1'b0;
		end
		else if (event_pulse)
		begin
			// Rising edge marks the event
			remain    <= RELOAD;
			stretched <= 1'b1;
		end
		else if (remain != '0)
		begin
			remain    <= remain - CNT_W'(1);
			stretched <= 1'b1;
		end
		else
		begin
			// Nothing pending: low
			stretched <= 1'b0;
		end
	end

endmodule : strobe_stretch

/* verif/debug_strobe_port_chk.sv */
// Assertion checker bound to the debug strobe port
`timescale 1ns/10ps
module debug_strobe_port_chk #(
	parameter int unsigned STATE_W = 5  // Protocol state code width
) (
	input wire logic               sys_clk,
	input wire logic               reset,
	input wire logic [3:0]         address,
	input wire logic               read,
	input wire logic               write,
	input wire logic [31:0]        writedata,
	input wire logic [3:0]         byteenable,
	input wire logic [31:0]        readdata,
	input wire logic               waitrequest,
	input wire logic [STATE_W-1:0] protocol_state,
	input wire logic               static_slot_start,
	input wire logic               minislot_start,
	input wire logic               cycle_start,
	input wire logic               network_idle_start,
	input wire logic               filtered_rx_chan_b,
	input wire logic               bus_guardian_attached,
	input wire logic               debug_output_one,
	input wire logic               debug_output_two
);
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	logic [3:0]         sel1;    // Shadow of pin one select
	logic [3:0]         sel2;    // Shadow of pin two select
	logic [3:0]         calm;    // Cycles since select write or guardian
	logic [STATE_W-1:0] ps_q;    // Previous protocol state
	logic [4:0]         chg;     // State change history
	logic               sel_wr;  // Accepted select write

	default clocking dflt @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	assign sel_wr = write && !waitrequest && address == dbg_port_pkg::OFS_PIN_SELECT;

	// Shadow selects; calm masks pins while a select or guardian settles
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			sel1 <= dbg_port_pkg::SEL_RESET;
			sel2 <= dbg_port_pkg::SEL_RESET;
			calm <= 4'h0;
			ps_q <= '0;
			chg  <= 5'h00;
		end
		else
		begin
			ps_q <= protocol_state;
			chg  <= {chg[3:0], protocol_state != ps_q};
			if (bus_guardian_attached || sel_wr)
				calm <= 4'h0;
			else if (calm != 4'hF)
				calm <= calm + 4'h1;
			if (sel_wr && byteenable[0])
				sel1 <= writedata[3:0];
			if (sel_wr && byteenable[1])
				sel2 <= writedata[11:8];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_ANSWER: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered after one wait cycle");
	AST_UNMAPPED: assert property (read && !waitrequest && address != 4'h0
		&& address != 4'h4 |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	AST_SEL_READ: assert property (read && !waitrequest && !address
		|-> readdata == {20'h0, sel2, 4'h0, sel1})
		else $error("select readback wrong");
	AST_GUARD: assert property (bus_guardian_attached[*3]
		|-> !debug_output_one && !debug_output_two)
		else $error("pin active with guardian attached");
	AST_STATIC: assert property (calm >= 2 && sel1 == dbg_port_pkg::FN_STATIC_SLOT
		|-> debug_output_one == $past(static_slot_start, 2))
		else $error("static slot pulse not one cycle");
	AST_MINI: assert property (calm >= 4 && sel1 == dbg_port_pkg::FN_MINISLOT
		|-> debug_output_one == ($past(minislot_start, 2) || $past(minislot_start, 3)
		|| $past(minislot_start, 4)))
		else $error("minislot pulse not three cycles");
	AST_STATE: assert property (calm >= 5 && sel1 == dbg_port_pkg::FN_STATE_CHANGE
		|-> debug_output_one == (|chg[4:2]))
		else $error("state change pulse wrong");
	AST_RX: assert property (calm >= 2 && sel2 == dbg_port_pkg::FN_RX_B
		|-> debug_output_two == $past(filtered_rx_chan_b, 2))
		else $error("receive data not passed through");
	AST_CYCLE_SET: assert property (calm >= 2 && sel1 == dbg_port_pkg::FN_CYCLE
		&& ($past(cycle_start, 2) || $past(network_idle_start, 2))
		|-> debug_output_one == $past(cycle_start, 2))
		else $error("cycle level edge wrong");
	AST_CYCLE_HOLD: assert property (calm >= 3 && sel1 == dbg_port_pkg::FN_CYCLE
		&& !$past(cycle_start, 2) && !$past(network_idle_start, 2) |-> $stable(debug_output_one))
		else $error("cycle level moved without cause");

	// Main scenarios reached
	CVR_STATIC: cover property (sel1 == dbg_port_pkg::FN_STATIC_SLOT && static_slot_start);
	CVR_WRITE: cover property (write && !waitrequest);
	CVR_GUARD: cover property (bus_guardian_attached[*3]);
endmodule : debug_strobe_port_chk

bind debug_strobe_port debug_strobe_port_chk #(.STATE_W(STATE_W)) chk (.*);

/* verif/pin_watch.sv */
// Analyser probe model timing one debug pin
`timescale 1ns/10ps
module pin_watch (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       pin,
	output logic      [7:0] rises,
	output logic      [7:0] width
);
	logic [7:0] run;  // Cycles high so far

	// Count rising edges and record each finished pulse width
	always_ff @(posedge sys_clk or posedge reset)
	begin
		if (reset)
		begin
			rises <= 8'h00;
			width <= 8'h00;
			run   <= 8'h00;
		end
		else if (pin)
		begin
			run <= run + 8'h01;
			if (run == 8'h00)
				rises <= rises + 8'h01;
		end
		else if (run != 8'h00)
		begin
			width <= run;
			run   <= 8'h00;
		end
	end
endmodule : pin_watch

/* verif/debug_strobe_port_tb_top.sv */
// Self-checking bench for the debug strobe port
`timescale 1ns/10ps
module debug_strobe_port_tb_top;
	logic        sys_clk = 1'b0, reset = 1'b1;
	logic [3:0]  address = 4'h0, byteenable = 4'h0;
	logic        read = 1'b0, write = 1'b0, waitrequest;
	logic [31:0] writedata = 32'h0, readdata, rd;
	logic [4:0]  protocol_state = 5'h00;
	logic        static_slot_start = 1'b0, minislot_start = 1'b0, cycle_start = 1'b0;
	logic        dyn_slot_start_chan_a = 1'b0, dyn_slot_start_chan_b = 1'b0;
	logic        frame_start_chan_a = 1'b0, frame_start_chan_b = 1'b0;
	logic        frame_end_chan_a = 1'b0, frame_end_chan_b = 1'b0;
	logic        frame_ok_chan_a = 1'b0, frame_ok_chan_b = 1'b0;
	logic        bit_tick_chan_a = 1'b0, bit_tick_chan_b = 1'b0;
	logic        network_idle_start = 1'b0, macrotick_tick = 1'b0, offset_corr_tick = 1'b0;
	logic        filtered_rx_chan_a = 1'b0, filtered_rx_chan_b = 1'b0;
	logic        bus_guardian_attached = 1'b0, debug_output_one, debug_output_two;
	logic [7:0]  rises1, rises2, width1, width2, r1, r2;
	int          fail_count = 0;
	int          n_compared = 0;

	always #4 sys_clk = ~sys_clk;

	pin_watch w1 (.sys_clk(sys_clk), .reset(reset), .pin(debug_output_one), .rises(rises1),
		.width(width1));
	pin_watch w2 (.sys_clk(sys_clk), .reset(reset), .pin(debug_output_two), .rises(rises2),
		.width(width2));
	debug_strobe_port dut (.*);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		byteenable <= 4'h3;
		do
		begin
			@(posedge sys_clk);
		end
		while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic set_sel(input logic [3:0] a, input logic [3:0] b);
		bus(1'b1, dbg_port_pkg::OFS_PIN_SELECT, {20'h0, b, 4'h0, a});
		r1 = rises1;
		r2 = rises2;
	endtask : set_sel

	// One-cycle event for the function code
	task automatic fire(input logic [3:0] c);
		@(posedge sys_clk);
		case (c)
			dbg_port_pkg::FN_STATE_CHANGE: protocol_state <= protocol_state + 5'h01;
			dbg_port_pkg::FN_STATIC_SLOT: static_slot_start <= 1'b1;
			dbg_port_pkg::FN_MINISLOT: minislot_start <= 1'b1;
			dbg_port_pkg::FN_DYN_SLOT_A: dyn_slot_start_chan_a <= 1'b1;
			dbg_port_pkg::FN_DYN_SLOT_B: dyn_slot_start_chan_b <= 1'b1;
			dbg_port_pkg::FN_FRAME_A: frame_start_chan_a <= 1'b1;
			dbg_port_pkg::FN_FRAME_B: frame_start_chan_b <= 1'b1;
			dbg_port_pkg::FN_MACROTICK: macrotick_tick <= 1'b1;
			dbg_port_pkg::FN_OFFSET_CORR: offset_corr_tick <= 1'b1;
			default: cycle_start <= 1'b1;
		endcase
		@(posedge sys_clk);
		{static_slot_start, minislot_start, dyn_slot_start_chan_a, dyn_slot_start_chan_b,
			frame_start_chan_a, frame_start_chan_b, macrotick_tick, offset_corr_tick,
			cycle_start} <= 9'h000;
	endtask : fire

	task automatic t_regs;
		bus(1'b0, dbg_port_pkg::OFS_PIN_SELECT, 32'h0);
		check("select_reset", rd, 32'h00000F0F);
		bus(1'b1, 4'h8, 32'hFFFFFFFF);
		bus(1'b0, 4'h8, 32'h0);
		check("unmapped", rd, 32'h0);
		set_sel(dbg_port_pkg::FN_MINISLOT, dbg_port_pkg::FN_VALID_B);
		bus(1'b0, dbg_port_pkg::OFS_PIN_SELECT, 32'h0);
		check("select_back", rd, 32'h00000D02);
	endtask : t_regs

	// Every strobed function except frame valid on both pins at once
	task automatic t_strobes;
		logic [3:0] codes [9];
		codes = '{dbg_port_pkg::FN_STATE_CHANGE, dbg_port_pkg::FN_STATIC_SLOT,
			dbg_port_pkg::FN_MINISLOT, dbg_port_pkg::FN_DYN_SLOT_A, dbg_port_pkg::FN_DYN_SLOT_B,
			dbg_port_pkg::FN_FRAME_A, dbg_port_pkg::FN_FRAME_B, dbg_port_pkg::FN_MACROTICK,
			dbg_port_pkg::FN_OFFSET_CORR};
		foreach (codes[i])
		begin
			set_sel(codes[i], codes[i]);
			fire(codes[i]);
			repeat (8) @(posedge sys_clk);
			check("rises_one", rises1, r1 + 8'h01);
			check("rises_two", rises2, r2 + 8'h01);
			check("width_one", width1, codes[i] == 4'h1 ? 1 : dbg_port_pkg::HOLD_CYCLES);
			check("width_two", width2, codes[i] == 4'h1 ? 1 : dbg_port_pkg::HOLD_CYCLES);
		end
	endtask : t_strobes

	// Events two cycles apart merge on pin one, stay apart on pin two
	task automatic t_merge;
		set_sel(dbg_port_pkg::FN_MINISLOT, dbg_port_pkg::FN_STATIC_SLOT);
		repeat (2)
		begin
			@(posedge sys_clk);
			{minislot_start, static_slot_start} <= 2'b11;
			@(posedge sys_clk);
			{minislot_start, static_slot_start} <= 2'b00;
		end
		repeat (8) @(posedge sys_clk);
		check("merge_rises", rises1, r1 + 8'h01);
		check("merge_width", width1, 32'h5);
		check("split_rises", rises2, r2 + 8'h02);
	endtask : t_merge

	// Valid frame shown only after the eleventh bit
	task automatic t_valid(input logic oka, input logic okb);
		set_sel(dbg_port_pkg::FN_VALID_A, dbg_port_pkg::FN_VALID_B);
		@(posedge sys_clk);
		{frame_end_chan_a, frame_end_chan_b, frame_ok_chan_a, frame_ok_chan_b} <= {2'b11, oka, okb};
		@(posedge sys_clk);
		{frame_end_chan_a, frame_end_chan_b} <= 2'b00;
		for (int i = 0; i < 11; i++)
		begin
			if (i == 10)
				repeat (4) @(posedge sys_clk);
			if (i == 10)
				check("early", {rises1, rises2}, {r1, r2});
			@(posedge sys_clk);
			{bit_tick_chan_a, bit_tick_chan_b} <= 2'b11;
			@(posedge sys_clk);
			{bit_tick_chan_a, bit_tick_chan_b} <= 2'b00;
		end
		repeat (3) @(posedge sys_clk);
		check("valid_at", {debug_output_one, debug_output_two}, {oka, okb});
		repeat (6) @(posedge sys_clk);
		check("valid_rises", {rises1, rises2}, {r1 + oka, r2 + okb});
	endtask : t_valid

	task automatic t_rx;
		logic [15:0] pat;
		pat = 16'hB39C;
		set_sel(dbg_port_pkg::FN_RX_A, dbg_port_pkg::FN_RX_B);
		for (int i = 0; i < 16; i++)
		begin
			@(posedge sys_clk);
			if (i > 2)
				check("rx", {debug_output_one, debug_output_two}, {pat[i-3], !pat[i-3]});
			filtered_rx_chan_a <= pat[i];
			filtered_rx_chan_b <= !pat[i];
		end
	endtask : t_rx

	task automatic t_cycle;
		set_sel(dbg_port_pkg::FN_CYCLE, dbg_port_pkg::FN_RX_B);
		fire(dbg_port_pkg::FN_CYCLE);
		repeat (8) @(posedge sys_clk);
		bus(1'b0, dbg_port_pkg::OFS_STATUS, 32'h0);
		check("status", rd, 32'h5);
		repeat (9) @(posedge sys_clk);
		network_idle_start <= 1'b1;
		@(posedge sys_clk);
		network_idle_start <= 1'b0;
		@(posedge sys_clk);
		check("cycle_high", debug_output_one, 32'h1);
		@(posedge sys_clk);
		check("cycle_low", debug_output_one, 32'h0);
	endtask : t_cycle

	// Guardian and unused codes keep both pins low
	task automatic t_quiet;
		set_sel(dbg_port_pkg::FN_MINISLOT, dbg_port_pkg::FN_MINISLOT);
		bus_guardian_attached <= 1'b1;
		fire(dbg_port_pkg::FN_MINISLOT);
		repeat (6) @(posedge sys_clk);
		check("guard", {rises1, rises2}, {r1, r2});
		bus_guardian_attached <= 1'b0;
		set_sel(4'hE, 4'hF);
		fire(dbg_port_pkg::FN_MINISLOT);
		fire(dbg_port_pkg::FN_STATIC_SLOT);
		repeat (6) @(posedge sys_clk);
		check("unused", {rises1, rises2}, {r1, r2});
	endtask : t_quiet

	task automatic final_report;
		if (fail_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	// Main sequence
	initial
	begin
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		t_regs();
		t_strobes();
		t_merge();
		t_valid(1'b1, 1'b0);
		t_valid(1'b0, 1'b1);
		t_rx();
		t_cycle();
		t_quiet();
		repeat (4) @(posedge sys_clk);
		final_report();
	end

	// Watchdog well beyond the expected run
	initial
	begin
		#40000;
		fail_count++;
		final_report();
	end
endmodule : debug_strobe_port_tb_top
